//--- fdm_glue.sv
// Contract
// - eight addresses; bit2 low reaches controller registers
// - bit2 high reaches drive control register
// - upper five address bits match switch
// - drive choice, disable; mini code 11 none
// - bit3 drives motor line with the same sense on both versions
// - bit6 single density; bits 4,7 unused
// - drive control stores inverted bus data
// - controller clock 1 MHz mini, 2 MHz full
// - DMA interrupt sets at count zero
// - status read or command write clears it
// - each interrupt strapped onto any request line
// - byte request never reaches request lines
// - chip reset held low resets controller
// - chip reset release starts home seek
// - controller data lines are inverted
// - mini three drives, full four drives
// - select codes status/command, track, sector, data
// - completion interrupt cleared by status/command access
// - byte request cleared by data register access
`timescale 1ns/10ps
`default_nettype none
module fdm_glue (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [fdm_pkg::ADR_W-1:0] bus_adr,
  input wire logic [fdm_pkg::DAT_W-1:0] bus_data_in,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  output logic [fdm_pkg::DAT_W-1:0] bus_data_out,
  output logic bus_done,
  input wire logic [fdm_pkg::SW_W-1:0] card_switch,
  input wire logic full_size,
  input wire logic [fdm_pkg::STRAP_W-1:0] done_strap,
  input wire logic [fdm_pkg::STRAP_W-1:0] dma_strap,
  input wire logic dma_count_zero,
  output logic [7:0] bus_irq_lines,
  output logic dma_count_irq,
  output logic chip_cs_n,
  output logic chip_re_n,
  output logic chip_we_n,
  output logic [fdm_pkg::SEL_W-1:0] register_select,
  input wire logic [fdm_pkg::DAT_W-1:0] chip_data_lines_in,
  output logic [fdm_pkg::DAT_W-1:0] chip_data_lines_out,
  output logic chip_data_lines_oe_n,
  output logic chip_reset_input_n,
  output logic chip_clk,
  input wire logic command_done_irq,
  input wire logic byte_transfer_request,
  output logic byte_request_seen,
  output logic [fdm_pkg::DRV_W-1:0] drive_select,
  output logic motor_line,
  output logic side_select,
  output logic single_density
);
  import fdm_pkg::*;

  localparam int SYNC_W = ADR_W + 2 * DAT_W + 2 + SW_W + 1 + 2 * STRAP_W + 3;

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [ADR_W-1:0] adr_s;
  logic [DAT_W-1:0] wdata_s;
  logic [DAT_W-1:0] cdata_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [SW_W-1:0] switch_s;
  logic full_s;
  logic [STRAP_W-1:0] done_strap_s;
  logic [STRAP_W-1:0] dma_strap_s;
  logic dma_zero_s;
  logic done_irq_s;
  logic byte_req_s;
  logic rd_n_prev_r;
  logic wr_n_prev_r;
  logic dma_zero_prev_r;
  logic rd_start;
  logic wr_start;
  logic card_hit;
  logic chip_start;
  logic ext_start;
  logic [DAT_W-1:0] drive_control_r;
  fdm_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic is_read_r;
  logic [CNT_W-1:0] rst_cnt_r;
  logic dma_set;
  logic dma_clear;

  // All pin inputs but clk and rst_n pass two flip-flops
  assign async_in = {bus_adr, bus_data_in, chip_data_lines_in, bus_rd_n, bus_wr_n,
                     card_switch, full_size, done_strap, dma_strap, dma_count_zero,
                     command_done_irq, byte_transfer_request};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  // Unpack the synchronised inputs
  assign {adr_s, wdata_s, cdata_s, rd_n_s, wr_n_s, switch_s, full_s, done_strap_s,
          dma_strap_s, dma_zero_s, done_irq_s, byte_req_s} = sync2_r;

  // Edge history of strobes and terminal count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
      dma_zero_prev_r <= 1'b0;
    end else begin
      rd_n_prev_r <= rd_n_s;
      wr_n_prev_r <= wr_n_s;
      dma_zero_prev_r <= dma_zero_s;
    end
  end

  // Falling strobe edges start one access
  assign rd_start = rd_n_prev_r && !rd_n_s && wr_n_s;
  assign wr_start = wr_n_prev_r && !wr_n_s && rd_n_s;

  // Card select on switch match
  assign card_hit = (adr_s[ADR_W-1:ADR_CARD_LO] == switch_s);

  // Split the eight-address window
  assign chip_start = card_hit && (rd_start || wr_start) && !adr_s[ADR_EXT_BIT] &&
                      state_r == FDM_IDLE && chip_reset_input_n;
  assign ext_start = card_hit && (rd_start || wr_start) && adr_s[ADR_EXT_BIT];

  // Drive control register, loaded with inverted bus data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_control_r <= DRIVE_CONTROL_RST;
    end else if (ext_start && wr_start) begin
      drive_control_r <= ~wdata_s;
    end
  end

  // Drive select decode, one-hot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drive_select <= '0;
    end else if (drive_control_r[DC_DISABLE] ||
                 (!full_s &&
                  drive_control_r[DC_DRIVE_LO +: 2] == DC_NO_DRIVE_MINI)) begin
      drive_select <= '0;
    end else begin
      drive_select <= DRV_W'(1) << drive_control_r[DC_DRIVE_LO +: 2];
    end
  end

  // Motor, side and density lines; bits 4 and 7 unused
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      motor_line <= 1'b0;
      side_select <= 1'b0;
      single_density <= 1'b0;
    end else begin
      motor_line <= drive_control_r[DC_MOTOR];
      side_select <= drive_control_r[DC_SIDE];
      single_density <= drive_control_r[DC_SINGLE_DEN];
    end
  end

  // Controller access sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= FDM_IDLE;
      cnt_r <= '0;
      is_read_r <= 1'b0;
    end else begin
      unique case (state_r)
        FDM_IDLE: begin
          if (chip_start) begin
            state_r <= FDM_STROBE;
            cnt_r <= CNT_W'(STROBE_CYC - 1);
            is_read_r <= rd_start;
          end
        end
        FDM_STROBE: begin
          if (cnt_r == '0) begin
            state_r <= FDM_HOLD;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        FDM_HOLD: begin
          state_r <= FDM_IDLE;
        end
        default: begin
          state_r <= FDM_IDLE;
        end
      endcase
    end
  end

  // Controller strobes and register select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chip_cs_n <= 1'b1;
      chip_re_n <= 1'b1;
      chip_we_n <= 1'b1;
      register_select <= SEL_STATUS_CMD;
    end else if (chip_start) begin
      chip_cs_n <= 1'b0;
      chip_re_n <= !rd_start;
      chip_we_n <= !wr_start;
      register_select <= adr_s[SEL_W-1:0];
    end else if (state_r == FDM_STROBE && cnt_r == '0) begin
      chip_cs_n <= 1'b1;
      chip_re_n <= 1'b1;
      chip_we_n <= 1'b1;
    end
  end

  // Write data driven inverted onto the controller lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chip_data_lines_out <= '1;
      chip_data_lines_oe_n <= 1'b1;
    end else if (chip_start && wr_start) begin
      chip_data_lines_out <= ~wdata_s;
      chip_data_lines_oe_n <= 1'b0;
    end else if (state_r == FDM_HOLD) begin
      chip_data_lines_oe_n <= 1'b1;
    end
  end

  // Read data returned true; drive control reads a fixed value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_data_out <= '0;
      bus_done <= 1'b0;
    end else begin
      bus_done <= (ext_start) || (state_r == FDM_HOLD);
      if (ext_start && rd_start) begin
        bus_data_out <= DRIVE_CONTROL_READ;
      end else if (state_r == FDM_STROBE && cnt_r == '0 && is_read_r) begin
        bus_data_out <= ~cdata_s;
      end
    end
  end

  // DMA count interrupt, set wins over clear
  assign dma_set = dma_zero_s && !dma_zero_prev_r;
  assign dma_clear = chip_start && adr_s[SEL_W-1:0] == SEL_STATUS_CMD;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_count_irq <= 1'b0;
    end else if (dma_set) begin
      dma_count_irq <= 1'b1;
    end else if (dma_clear) begin
      dma_count_irq <= 1'b0;
    end
  end

  // Byte request only as a status level, never an interrupt
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_request_seen <= 1'b0;
    end else begin
      byte_request_seen <= byte_req_s;
    end
  end

  // Controller reset held low through reset and a minimum time after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt_r <= '0;
      chip_reset_input_n <= 1'b0;
    end else if (rst_cnt_r != CNT_W'(CHIP_RST_CYC)) begin
      rst_cnt_r <= rst_cnt_r + CNT_W'(1);
    end else begin
      chip_reset_input_n <= 1'b1;
    end
  end

  // Controller clock per board version
  fdm_clkdiv u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .full_size(full_s),
    .chip_clk(chip_clk)
  );

  // Interrupt strapping onto request lines
  fdm_irq_route u_irq (
    .clk(clk),
    .rst_n(rst_n),
    .done_irq(done_irq_s),
    .dma_irq(dma_count_irq),
    .done_strap(done_strap_s),
    .dma_strap(dma_strap_s),
    .bus_irq_lines(bus_irq_lines)
  );
endmodule
`default_nettype wire

//--- fdm_pkg.sv
`default_nettype none
package fdm_pkg;

  // Bus and data widths
  localparam int ADR_W = 8;
  localparam int DAT_W = 8;
  localparam int SW_W = 5;
  localparam int SEL_W = 2;
  localparam int STRAP_W = 3;
  localparam int DRV_W = 4;
  localparam int CNT_W = 12;

  // Address fields
  localparam int ADR_EXT_BIT = 2;
  localparam int ADR_CARD_LO = 3;

  // Controller register-select codes
  localparam logic [1:0] SEL_STATUS_CMD = 2'h0;
  localparam logic [1:0] SEL_TRACK = 2'h1;
  localparam logic [1:0] SEL_SECTOR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  // Drive control field positions
  localparam int DC_DRIVE_LO = 0;
  localparam int DC_DISABLE = 2;
  localparam int DC_MOTOR = 3;
  localparam int DC_SIDE = 5;
  localparam int DC_SINGLE_DEN = 6;
  localparam logic [1:0] DC_NO_DRIVE_MINI = 2'h3;

  // Drive control value after reset and fixed read value
  localparam logic [7:0] DRIVE_CONTROL_RST = 8'h04;
  localparam logic [7:0] DRIVE_CONTROL_READ = 8'h00;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CHIP_MHZ_MINI = 1;
  localparam int CHIP_MHZ_FULL = 2;
  localparam int HALF_MINI_CYC = CLK_MHZ / (2 * CHIP_MHZ_MINI);
  localparam int HALF_FULL_CYC = CLK_MHZ / (2 * CHIP_MHZ_FULL);
  localparam int STROBE_NS = 500;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CHIP_RST_NS = 10000;
  localparam int CHIP_RST_CYC = (CHIP_RST_NS * CLK_MHZ + 999) / 1000;

  // Controller access sequencer
  typedef enum logic [1:0] {
    FDM_IDLE = 2'h0,
    FDM_STROBE = 2'h1,
    FDM_HOLD = 2'h3
  } fdm_state_t;

endpackage
`default_nettype wire

//--- fdm_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
module fdm_clkdiv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic full_size,
  output logic chip_clk
);
  import fdm_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] half_cyc;

  // Half period picks 1 MHz or 2 MHz
  assign half_cyc = full_size ? CNT_W'(HALF_FULL_CYC) : CNT_W'(HALF_MINI_CYC);

  // Free-running square wave for the controller
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      chip_clk <= 1'b0;
    end else if (cnt_r >= half_cyc - CNT_W'(1)) begin
      cnt_r <= '0;
      chip_clk <= ~chip_clk;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

//--- fdm_irq_route.sv
`timescale 1ns/10ps
`default_nettype none
module fdm_irq_route (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic done_irq,
  input wire logic dma_irq,
  input wire logic [fdm_pkg::STRAP_W-1:0] done_strap,
  input wire logic [fdm_pkg::STRAP_W-1:0] dma_strap,
  output logic [7:0] bus_irq_lines
);
  import fdm_pkg::*;

  // Each source lands on the one line its strap names; no data request path
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_line
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          bus_irq_lines[i] <= 1'b0;
        end else begin
          bus_irq_lines[i] <= (done_irq && done_strap == STRAP_W'(i)) ||
                              (dma_irq && dma_strap == STRAP_W'(i));
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- fdm_glue_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module fdm_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_done,
  input wire logic full_size,
  input wire logic chip_cs_n,
  input wire logic chip_we_n,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] chip_data_lines_out,
  input wire logic chip_data_lines_oe_n,
  input wire logic chip_reset_input_n,
  input wire logic [3:0] drive_select,
  input wire logic motor_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Handshake and strobe timing
  a_done_pulse: assert property (bus_done |=> !bus_done) else $error("done too long");
  a_strobe_len: assert property ($fell(chip_cs_n) |-> ##49 !chip_cs_n ##1 chip_cs_n)
    else $error("strobe length wrong");
  a_done_after: assert property ($rose(chip_cs_n) |-> ##[1:2] bus_done) else $error("no done");
  a_write_cs: assert property (!chip_we_n |-> !chip_cs_n) else $error("write without select");
  a_write_inv: assert property (!chip_we_n |-> chip_data_lines_out == ~bus_data_in)
    else $error("write data not inverted");
  a_write_drives: assert property (!chip_we_n |-> !chip_data_lines_oe_n)
    else $error("write data lines not driven");
  // Drive outputs
  a_sel_onehot: assert property ($onehot0(drive_select)) else $error("select not one-hot");
  a_mini_three: assert property (!full_size |-> !drive_select[3]) else $error("fourth drive");
  a_drive_hold: assert property ($changed(motor_line) |-> $past(bus_done))
    else $error("motor changed without write");
  // Controller reset
  a_chip_rst: assert property ($rose(rst_n) |-> !chip_reset_input_n [*8])
    else $error("chip reset too short");
  a_ctrl_block: assert property (!chip_reset_input_n |-> chip_cs_n)
    else $error("access during chip reset");
  // Main scenarios
  cover property ($fell(chip_we_n));
  cover property (drive_select[3]);
  cover property ($rose(chip_reset_input_n));
endmodule
bind fdm_glue fdm_chk chk_u (.clk, .rst_n, .bus_done, .full_size, .chip_cs_n, .chip_we_n,
  .bus_data_in, .chip_data_lines_out, .chip_data_lines_oe_n, .chip_reset_input_n,
  .drive_select, .motor_line);
`default_nettype wire

//--- fdm_chip_model.sv
`timescale 1ns/10ps
`default_nettype none
module fdm_chip_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic re_n,
  input wire logic we_n,
  input wire logic [1:0] sel,
  input wire logic [7:0] data_in,
  input wire logic done_req,
  input wire logic byte_req_in,
  output logic [7:0] data_out,
  output logic done_irq,
  output logic byte_req
);
  logic [7:0] cmd_r, trk_r, sec_r, dat_r, sts_r;
  // Registers, inverted bus, reset loading
  always @(posedge clk) begin
    if (!reset_n) begin
      cmd_r <= 8'h03;
      sts_r <= 8'h00;
      sec_r <= 8'h01;
      data_out <= 8'hA5;
    end else begin
      if (!cs_n && !we_n) begin
        case (sel)
          2'h0: cmd_r <= ~data_in;
          2'h1: trk_r <= ~data_in;
          2'h2: sec_r <= ~data_in;
          default: dat_r <= ~data_in;
        endcase
      end
      // Released bus toggles
      data_out <= (!cs_n && !re_n) ? ~(sel == 2'h0 ? sts_r : sel == 2'h1 ? trk_r :
        sel == 2'h2 ? sec_r : dat_r) : ~data_out;
    end
  end
  // Completion and byte request lines
  always @(posedge clk) begin
    if (!reset_n) begin
      done_irq <= 1'b0;
      byte_req <= 1'b0;
    end else begin
      done_irq <= done_req | (done_irq & ~(!cs_n && sel == 2'h0));
      byte_req <= byte_req_in | (byte_req & ~(!cs_n && sel == 2'h3));
    end
  end
endmodule
`default_nettype wire

//--- test_floppy_module_host_glue.sv
`timescale 1ns/10ps
`default_nettype none
module test_floppy_module_host_glue;
  import fdm_pkg::*;
  logic clk = 0, rst_n = 0, rd_n = 1, wr_n = 1, full = 0, dz = 0, dreq = 0, qreq = 0;
  logic [7:0] adr = 0, din = 0, bdo, irq, cdo, cdi;
  logic [4:0] sw = 5'h15;
  logic [2:0] dstrap = 3'h2, mstrap = 3'h5;
  logic done, dirq, cs_n, re_n, we_n, oe_n, crst_n, cclk, cdone, cdrq, seen, mot, side, den;
  logic [1:0] rsel;
  logic [3:0] dsel;
  logic [7:0] vals [4];
  int bad_count = 0, total_checks = 0;
  logic [8:0] exp_q [$];
  always #5 clk = ~clk;
  fdm_glue dut_u (.clk(clk), .rst_n(rst_n), .bus_adr(adr), .bus_data_in(din), .bus_rd_n(rd_n),
    .bus_wr_n(wr_n), .bus_data_out(bdo), .bus_done(done), .card_switch(sw), .full_size(full),
    .done_strap(dstrap), .dma_strap(mstrap), .dma_count_zero(dz), .bus_irq_lines(irq),
    .dma_count_irq(dirq), .chip_cs_n(cs_n), .chip_re_n(re_n), .chip_we_n(we_n),
    .register_select(rsel), .chip_data_lines_in(cdi), .chip_data_lines_out(cdo),
    .chip_data_lines_oe_n(oe_n), .chip_reset_input_n(crst_n), .chip_clk(cclk),
    .command_done_irq(cdone), .byte_transfer_request(cdrq), .byte_request_seen(seen),
    .drive_select(dsel), .motor_line(mot), .side_select(side), .single_density(den));
  fdm_chip_model chip_u (.clk(clk), .reset_n(crst_n), .cs_n(cs_n), .re_n(re_n), .we_n(we_n),
    .sel(rsel), .data_in(cdo), .done_req(dreq), .byte_req_in(qreq), .data_out(cdi),
    .done_irq(cdone), .byte_req(cdrq));
  task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One host access; rsp says whether an answer is due
  task automatic acc(logic [7:0] a, logic [7:0] d, bit wr, bit rsp, logic [8:0] e);
    int n;
    @(posedge clk);
    adr <= a;
    din <= d;
    repeat (4) @(posedge clk);
    if (rsp) exp_q.push_back(e);
    if (wr) wr_n <= 1'b0;
    else rd_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 120);
    chk("bus_done", {7'h0, rsp}, {7'h0, n < 120});
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic dc_write(logic [7:0] d);
    logic [7:0] c;
    logic [3:0] e;
    c = ~d;
    e = (c[2] || (!full && c[1:0] == 2'h3)) ? 4'h0 : 4'h1 << c[1:0];
    acc({sw, 1'b1, 2'($urandom)}, d, 1, 1, 9'h0);
    chk("drive_select", {4'h0, e}, {4'h0, dsel});
    chk("drive bits", {5'h0, c[6], c[5], c[3]}, {5'h0, den, side, mot});
  endtask
  task automatic rate(int e);
    int k;
    logic p;
    k = 0;
    p = cclk;
    repeat (1000) begin
      @(posedge clk);
      if (cclk && !p) k++;
      p = cclk;
    end
    chk("chip_clk rises", 8'(e), 8'(k));
  endtask
  // Result watcher
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected done", 8'h0, 8'h1);
      else if (exp_q[0][8]) chk("read data", exp_q[0][7:0], bdo);
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h2868));
    repeat (20) @(posedge clk);
    dstrap <= 3'($urandom);
    mstrap <= 3'($urandom);
    rst_n <= 1'b1;
    acc({sw, 3'h1}, 8'h77, 1, 0, 9'h0);
    repeat (CHIP_RST_CYC - 130) @(posedge clk);
    chk("chip reset held", 8'h0, {7'h0, crst_n});
    repeat (40) @(posedge clk);
    chk("chip reset released", 8'h1, {7'h0, crst_n});
    $display("test reset done");
    for (int v = 0; v < 2; v++) begin
      full <= v[0];
      repeat (10) @(posedge clk);
      for (int i = 0; i < 4; i++) dc_write(~8'(i));
      dc_write(8'hFB);
      repeat (3) dc_write(8'($urandom));
    end
    acc({sw, 3'h7}, 8'h00, 0, 1, 9'h100);
    dc_write(8'hFE);
    acc({~sw, 3'h4}, 8'h00, 1, 0, 9'h0);
    chk("drive_select kept", 8'h02, {4'h0, dsel});
    $display("test drive control done");
    acc({sw, 3'h2}, 8'h00, 0, 1, 9'h101);
    for (int i = 1; i < 4; i++) begin
      vals[i] = 8'($urandom);
      acc({sw, 1'b0, 2'(i)}, vals[i], 1, 1, 9'h0);
      acc({sw, 1'b0, 2'(i)}, 8'h00, 0, 1, {1'b1, vals[i]});
    end
    $display("test controller registers done");
    dz <= 1'b1;
    repeat (10) @(posedge clk);
    chk("dma irq set", 8'h01, {7'h0, dirq});
    chk("irq lines dma", 8'(8'h01 << mstrap), irq);
    acc({sw, 3'h0}, 8'h00, 0, 1, 9'h100);
    chk("dma irq status clear", 8'h00, {7'h0, dirq});
    dz <= 1'b0;
    repeat (5) @(posedge clk);
    dz <= 1'b1;
    repeat (10) @(posedge clk);
    chk("dma irq again", 8'h01, {7'h0, dirq});
    acc({sw, 3'h0}, 8'hD0, 1, 1, 9'h0);
    chk("dma irq command clear", 8'h00, {7'h0, dirq});
    dz <= 1'b0;
    dreq <= 1'b1;
    @(posedge clk);
    dreq <= 1'b0;
    repeat (10) @(posedge clk);
    chk("irq lines done", 8'(8'h01 << dstrap), irq);
    acc({sw, 3'h0}, 8'h00, 0, 1, 9'h100);
    chk("irq lines cleared", 8'h00, irq);
    qreq <= 1'b1;
    @(posedge clk);
    qreq <= 1'b0;
    repeat (10) @(posedge clk);
    chk("byte request seen", 8'h01, {7'h0, seen});
    chk("irq lines byte req", 8'h00, irq);
    acc({sw, 3'h3}, 8'h00, 0, 1, {1'b1, vals[3]});
    chk("byte request gone", 8'h00, {7'h0, seen});
    $display("test interrupts done");
    rate(1000 / (2 * HALF_FULL_CYC));
    full <= 1'b0;
    repeat (20) @(posedge clk);
    rate(1000 / (2 * HALF_MINI_CYC));
    $display("test clock rate done");
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
